//--- rtl/meg_pkg.sv
// Shared constants for the modulator and emitter guard configuration bank
package meg_pkg;

   // ----------------------------------------------------------------
   // Register map of the device end
   // ----------------------------------------------------------------
   localparam int NREG = 15;
   localparam int IX_MODULATOR_COMMON_BIAS_CFG = 0;
   localparam int IX_MODULATOR_COMMON_MODE_CFG = 1;
   localparam int IX_FIRST_MODULATOR_MAIN_CFG = 2;
   localparam int IX_FIRST_MODULATOR_SCALE_CFG = 3;
   localparam int IX_FIRST_MODULATOR_SEQA_INTEGRATOR = 4;
   localparam int IX_FIRST_MODULATOR_SEQA_REFCURRENT = 5;
   localparam int IX_FIRST_MODULATOR_SEQB_INTEGRATOR = 6;
   localparam int IX_FIRST_MODULATOR_SEQB_REFCURRENT = 7;
   localparam int IX_SECOND_MODULATOR_MAIN_CFG = 8;
   localparam int IX_SECOND_MODULATOR_SCALE_CFG = 9;
   localparam int IX_SECOND_MODULATOR_SEQA_INTEGRATOR = 10;
   localparam int IX_SECOND_MODULATOR_SEQA_REFCURRENT = 11;
   localparam int IX_SECOND_MODULATOR_SEQB_INTEGRATOR = 12;
   localparam int IX_SECOND_MODULATOR_SEQB_REFCURRENT = 13;
   localparam int IX_EMITTER_GUARD_CFG = 14;

   localparam logic [7:0] REG_ADDR [NREG] = '{
      8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20,
      8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h28};
   localparam logic [7:0] REG_RESET [NREG] = '{
      8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   // Bits that exist; others drop on write, read zero
   localparam logic [7:0] REG_MASK [NREG] = '{
      8'h03, 8'h7F, 8'h3F, 8'h0F, 8'h3F, 8'hFF, 8'h2F, 8'hFF,
      8'h3F, 8'h0F, 8'h3F, 8'hFF, 8'h2F, 8'hFF, 8'hFF};

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIAS_LSB = 0;
   localparam int DSM_MODE_LSB = 5;
   localparam int COMP_MODE_LSB = 3;
   localparam int REF_MODE_LSB = 0;
   localparam int SRC_BIT = 5;
   localparam int EN_BIT = 4;
   localparam int DIR_BIT = 3;
   localparam int FS_LSB = 0;
   localparam int SCALE_LSB = 0;
   localparam int AMPL_BIT = 5;
   localparam int CAP_LSB = 0;
   localparam int WD_OFF_BIT = 7;
   localparam int SAFETY_OFF_BIT = 6;
   localparam int THR_LSB = 4;
   localparam int SUPPLY_WAIT_LSB = 2;
   localparam int GROUND_WAIT_LSB = 0;

   // ----------------------------------------------------------------
   // Legal code limits and analog settings
   // ----------------------------------------------------------------
   localparam logic [3:0] SCALE_0P625 = 4'h4;
   localparam logic [3:0] SCALE_1P000 = 4'h7;
   localparam logic [4:0] CAP_MAX = 5'h0F;
   localparam logic [7:0] IREF_MAX = 8'h1F;
   localparam logic [7:0] THR_MV [4] = '{8'd50, 8'd100, 8'd150, 8'd200};

   // ----------------------------------------------------------------
   // Short detection settling waits
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 25;
   localparam int SUPPLY_WAIT_US [4] = '{2, 4, 8, 1};
   localparam int GROUND_WAIT_US [4] = '{2, 4, 8, 12};
   localparam int WAIT_CNT_MAX = 12 * CLK_MHZ;

   // ----------------------------------------------------------------
   // Host command registers
   // ----------------------------------------------------------------
   localparam logic [2:0] HOST_TARGET = 3'h0;
   localparam logic [2:0] HOST_WDATA = 3'h1;
   localparam logic [2:0] HOST_GO = 3'h2;
   localparam logic [2:0] HOST_STATUS = 3'h3;
   localparam logic [2:0] HOST_RDATA = 3'h4;
   localparam int GO_WRITE_BIT = 0;
   localparam int GO_READ_BIT = 1;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DONE_BIT = 1;

   typedef enum logic [1:0] {
      MEG_IDLE,
      MEG_ISSUE,
      MEG_CAPTURE
   } meg_host_state_e;

endpackage

//--- rtl/meg_link_if.sv
// Register link between the host controller and the configuration bank
`timescale 1ns/1ns
interface meg_link_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;

   modport dev (
      input addr,
      input wdata,
      input wr,
      input rd,
      output rdata
   );

   modport host (
      output addr,
      output wdata,
      output wr,
      output rd,
      input rdata
   );
endinterface

//--- rtl/meg_host.sv
// Host end: turns software commands into register link transfers
`timescale 1ns/1ns
module meg_host (
   input wire logic clk,
   input wire logic rstn,
   meg_link_if.host link,
   input wire logic [2:0] sw_addr,
   input wire logic [7:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [7:0] sw_rdata
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   meg_pkg::meg_host_state_e st_q, st_d;
   logic [7:0] target_q, target_d;
   logic [7:0] wdata_q, wdata_d;
   logic [7:0] rbuf_q, rbuf_d;
   logic done_q, done_d;
   logic is_read_q, is_read_d;
   logic [7:0] l_addr_q, l_addr_d;
   logic [7:0] l_wdata_q, l_wdata_d;
   logic l_wr_q, l_wr_d;
   logic l_rd_q, l_rd_d;
   logic [7:0] sw_rdata_q, sw_rdata_d;
   logic busy;

   assign busy = (st_q != meg_pkg::MEG_IDLE);

   // Next state: commands during a transfer are ignored, not queued
   always_comb begin
      st_d = st_q;
      target_d = target_q;
      wdata_d = wdata_q;
      rbuf_d = rbuf_q;
      done_d = done_q;
      is_read_d = is_read_q;
      l_addr_d = l_addr_q;
      l_wdata_d = l_wdata_q;
      l_wr_d = 1'b0;
      l_rd_d = 1'b0;
      sw_rdata_d = 8'h00;
      if (sw_wr) begin
         unique case (sw_addr)
            meg_pkg::HOST_TARGET: target_d = sw_wdata;
            meg_pkg::HOST_WDATA: wdata_d = sw_wdata;
            meg_pkg::HOST_STATUS: begin
               if (sw_wdata[meg_pkg::ST_DONE_BIT]) begin
                  done_d = 1'b0;
               end
            end
            default: ;
         endcase
      end
      if (sw_rd) begin
         unique case (sw_addr)
            meg_pkg::HOST_TARGET: sw_rdata_d = target_q;
            meg_pkg::HOST_WDATA: sw_rdata_d = wdata_q;
            meg_pkg::HOST_STATUS: sw_rdata_d = {6'h00, done_q, busy};
            meg_pkg::HOST_RDATA: sw_rdata_d = rbuf_q;
            default: sw_rdata_d = 8'h00;
         endcase
      end
      unique case (st_q)
         meg_pkg::MEG_IDLE: begin
            if (sw_wr && sw_addr == meg_pkg::HOST_GO &&
                (sw_wdata[meg_pkg::GO_WRITE_BIT] ||
                 sw_wdata[meg_pkg::GO_READ_BIT])) begin
               // Read wins when both bits are set
               is_read_d = sw_wdata[meg_pkg::GO_READ_BIT];
               st_d = meg_pkg::MEG_ISSUE;
            end
         end
         meg_pkg::MEG_ISSUE: begin
            l_addr_d = target_q;
            l_wdata_d = wdata_q;
            l_wr_d = !is_read_q;
            l_rd_d = is_read_q;
            st_d = meg_pkg::MEG_CAPTURE;
         end
         meg_pkg::MEG_CAPTURE: begin
            // Read data follow the strobe by a cycle
            if (!l_wr_q && !l_rd_q) begin
               if (is_read_q) begin
                  rbuf_d = link.rdata;
               end
               done_d = 1'b1;
               st_d = meg_pkg::MEG_IDLE;
            end
         end
      endcase
   end

   // Registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= meg_pkg::MEG_IDLE;
         target_q <= 8'h00;
         wdata_q <= 8'h00;
         rbuf_q <= 8'h00;
         done_q <= 1'b0;
         is_read_q <= 1'b0;
         l_addr_q <= 8'h00;
         l_wdata_q <= 8'h00;
         l_wr_q <= 1'b0;
         l_rd_q <= 1'b0;
         sw_rdata_q <= 8'h00;
      end else begin
         st_q <= st_d;
         target_q <= target_d;
         wdata_q <= wdata_d;
         rbuf_q <= rbuf_d;
         done_q <= done_d;
         is_read_q <= is_read_d;
         l_addr_q <= l_addr_d;
         l_wdata_q <= l_wdata_d;
         l_wr_q <= l_wr_d;
         l_rd_q <= l_rd_d;
         sw_rdata_q <= sw_rdata_d;
      end
   end

   assign link.addr = l_addr_q;
   assign link.wdata = l_wdata_q;
   assign link.wr = l_wr_q;
   assign link.rd = l_rd_q;
   assign sw_rdata = sw_rdata_q;

endmodule

//--- rtl/meg_device.sv
// Device end: modulator and emitter guard configuration register bank
// Summary of operation
// (RULE_01) First enable bit powers first modulator
// (RULE_02) Second enable bit powers second modulator
// (RULE_03) Source bit one borrows other DAC
// (RULE_04) Source bit two borrows other DAC
// (RULE_05) Offset full scale doubles per code
// (RULE_06) Scale factor only four or seven
// (RULE_07) Cap field per modulator and sequencer
// (RULE_08) Reference current above 31 forbidden
// (RULE_09) Bit five selects integrator amplitude scale
// (RULE_10) Bias and mode stay zero
// (RULE_11) Comparator, reference modes stay zero
// (RULE_12) Offset direction bit stays zero
// (RULE_13) Bit seven turns emitter watchdog off
// (RULE_14) Bit six stops short signal evaluation
// (RULE_15) Threshold codes give 50 to 200 mV
// (RULE_16) Supply wait codes: 2, 4, 8, 1 us
// (RULE_17) Ground wait codes: 2, 4, 8, 12 us
// (RULE_18) One wait pair shared by all channels
// (RULE_19) Unlisted bits read zero, ignore writes
// (RULE_20) Fields read back last written value
`timescale 1ns/1ns
module meg_device (
   input wire logic clk,
   input wire logic rstn,
   meg_link_if.dev link,
   input wire logic detect_on,
   input wire logic short_supply_pin,
   input wire logic short_ground_pin,
   output logic first_converter_enable,
   output logic second_converter_enable,
   output logic first_offset_source_select,
   output logic second_offset_source_select,
   output logic [7:0] first_offset_full_scale,
   output logic [7:0] second_offset_full_scale,
   output logic [3:0] seq_amplitude_scale,
   output logic [4:0] seq_integrator_cap [4],
   output logic [7:0] seq_reference_current [4],
   output logic [7:0] threshold_mv,
   output logic emitter_watchdog_active,
   output logic supply_result_valid,
   output logic ground_result_valid,
   output logic short_to_supply,
   output logic short_to_ground,
   output logic config_code_illegal
);

   // ----------------------------------------------------------------
   // Register file and link slave
   // ----------------------------------------------------------------
   logic [7:0] regs_q [meg_pkg::NREG];
   logic [7:0] regs_d [meg_pkg::NREG];
   logic [7:0] rdata_q, rdata_d;

   // Address match; 0x27 and all else unmapped
   always_comb begin
      regs_d = regs_q;
      rdata_d = 8'h00;
      for (int i = 0; i < meg_pkg::NREG; i++) begin
         if (link.addr == meg_pkg::REG_ADDR[i]) begin
            if (link.wr) begin
               regs_d[i] = link.wdata & meg_pkg::REG_MASK[i]; // [RULE_19]
            end
            if (link.rd) begin
               rdata_d = regs_q[i]; // [RULE_20]
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         regs_q <= meg_pkg::REG_RESET;
         rdata_q <= 8'h00;
      end else begin
         regs_q <= regs_d;
         rdata_q <= rdata_d;
      end
   end

   assign link.rdata = rdata_q;

   // ----------------------------------------------------------------
   // Field views
   // ----------------------------------------------------------------
   logic [7:0] main1, main2, guard;
   logic [1:0] thr_code, sup_code, gnd_code;
   logic wd_off, safety_off;

   assign main1 = regs_q[meg_pkg::IX_FIRST_MODULATOR_MAIN_CFG];
   assign main2 = regs_q[meg_pkg::IX_SECOND_MODULATOR_MAIN_CFG];
   assign guard = regs_q[meg_pkg::IX_EMITTER_GUARD_CFG];
   assign wd_off = guard[meg_pkg::WD_OFF_BIT];
   assign safety_off = guard[meg_pkg::SAFETY_OFF_BIT];
   assign thr_code = guard[meg_pkg::THR_LSB +: 2];
   assign sup_code = guard[meg_pkg::SUPPLY_WAIT_LSB +: 2];
   assign gnd_code = guard[meg_pkg::GROUND_WAIT_LSB +: 2];

   // Order: first/seqa, first/seqb, second/seqa, second/seqb
   localparam int CAP_IX [4] = '{
      meg_pkg::IX_FIRST_MODULATOR_SEQA_INTEGRATOR,
      meg_pkg::IX_FIRST_MODULATOR_SEQB_INTEGRATOR,
      meg_pkg::IX_SECOND_MODULATOR_SEQA_INTEGRATOR,
      meg_pkg::IX_SECOND_MODULATOR_SEQB_INTEGRATOR};
   localparam int IREF_IX [4] = '{
      meg_pkg::IX_FIRST_MODULATOR_SEQA_REFCURRENT,
      meg_pkg::IX_FIRST_MODULATOR_SEQB_REFCURRENT,
      meg_pkg::IX_SECOND_MODULATOR_SEQA_REFCURRENT,
      meg_pkg::IX_SECOND_MODULATOR_SEQB_REFCURRENT};

   // ----------------------------------------------------------------
   // Modulator control outputs
   // ----------------------------------------------------------------
   logic en1_q, en1_d, en2_q, en2_d;
   logic src1_q, src1_d, src2_q, src2_d;
   logic [7:0] fs1_q, fs1_d, fs2_q, fs2_d;
   logic [3:0] ampl_q, ampl_d;
   logic [4:0] cap_q [4];
   logic [4:0] cap_d [4];
   logic [7:0] iref_q [4];
   logic [7:0] iref_d [4];
   logic illegal_q, illegal_d;
   logic [7:0] thr_q, thr_d;

   // Decode fields; full scale in microamps
   always_comb begin
      en1_d = main1[meg_pkg::EN_BIT]; // [RULE_01]
      en2_d = main2[meg_pkg::EN_BIT]; // [RULE_02]
      src1_d = main1[meg_pkg::SRC_BIT]; // [RULE_03]
      src2_d = main2[meg_pkg::SRC_BIT]; // [RULE_04]
      fs1_d = 8'h01 << main1[meg_pkg::FS_LSB +: 3]; // [RULE_05]
      fs2_d = 8'h01 << main2[meg_pkg::FS_LSB +: 3]; // [RULE_05]
      thr_d = meg_pkg::THR_MV[thr_code]; // [RULE_15]
      illegal_d = 1'b0;
      for (int k = 0; k < 4; k++) begin
         // Sequencer b has a four-bit capacitance field
         cap_d[k] = regs_q[CAP_IX[k]][meg_pkg::CAP_LSB +: 5]; // [RULE_07]
         ampl_d[k] = regs_q[CAP_IX[k]][meg_pkg::AMPL_BIT]; // [RULE_09]
         iref_d[k] = regs_q[IREF_IX[k]]; // [RULE_08]
         if (cap_d[k] > meg_pkg::CAP_MAX ||
             iref_d[k] > meg_pkg::IREF_MAX) begin
            illegal_d = 1'b1; // [RULE_07] [RULE_08]
         end
      end
      // Forbidden codes kept as written, only flagged
      for (int m = 0; m < 2; m++) begin
         if (regs_q[3 + 6 * m][meg_pkg::SCALE_LSB +: 4] !=
                meg_pkg::SCALE_0P625 &&
             regs_q[3 + 6 * m][meg_pkg::SCALE_LSB +: 4] !=
                meg_pkg::SCALE_1P000) begin
            illegal_d = 1'b1; // [RULE_06]
         end
      end
      if (main1[meg_pkg::DIR_BIT] || main2[meg_pkg::DIR_BIT]) begin
         illegal_d = 1'b1; // [RULE_12]
      end
      if (regs_q[meg_pkg::IX_MODULATOR_COMMON_BIAS_CFG] != 8'h00 ||
          regs_q[meg_pkg::IX_MODULATOR_COMMON_MODE_CFG] != 8'h00) begin
         illegal_d = 1'b1; // [RULE_10] [RULE_11]
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         en1_q <= 1'b0;
         en2_q <= 1'b0;
         src1_q <= 1'b0;
         src2_q <= 1'b0;
         fs1_q <= 8'h10;
         fs2_q <= 8'h10;
         ampl_q <= 4'h0;
         cap_q <= '{default: 5'h00};
         iref_q <= '{default: 8'h00};
         illegal_q <= 1'b1;
         thr_q <= 8'h32;
      end else begin
         en1_q <= en1_d;
         en2_q <= en2_d;
         src1_q <= src1_d;
         src2_q <= src2_d;
         fs1_q <= fs1_d;
         fs2_q <= fs2_d;
         ampl_q <= ampl_d;
         cap_q <= cap_d;
         iref_q <= iref_d;
         illegal_q <= illegal_d;
         thr_q <= thr_d;
      end
   end

   // ----------------------------------------------------------------
   // Emitter short detection timing
   // ----------------------------------------------------------------
   logic sup_s1, sup_s2, gnd_s1, gnd_s2;
   logic [8:0] cnt_q, cnt_d;
   logic [8:0] sup_cyc, gnd_cyc;
   logic wd_act_q, wd_act_d;
   logic sup_v_q, sup_v_d, gnd_v_q, gnd_v_d;
   logic sup_f_q, sup_f_d, gnd_f_q, gnd_f_d;

   // Short sense pins are asynchronous to clk
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sup_s1 <= 1'b0;
         sup_s2 <= 1'b0;
         gnd_s1 <= 1'b0;
         gnd_s2 <= 1'b0;
      end else begin
         sup_s1 <= short_supply_pin;
         sup_s2 <= sup_s1;
         gnd_s1 <= short_ground_pin;
         gnd_s2 <= gnd_s1;
      end
   end

   // One counter for all channels, so one wait pair
   always_comb begin
      sup_cyc = 9'(meg_pkg::SUPPLY_WAIT_US[sup_code] * meg_pkg::CLK_MHZ);
      gnd_cyc = 9'(meg_pkg::GROUND_WAIT_US[gnd_code] * meg_pkg::CLK_MHZ);
      wd_act_d = !wd_off; // [RULE_13]
      cnt_d = cnt_q;
      if (wd_off || !detect_on) begin
         cnt_d = 9'h000; // [RULE_13]
      end else if (cnt_q < 9'(meg_pkg::WAIT_CNT_MAX)) begin
         cnt_d = cnt_q + 9'h001; // [RULE_18]
      end
      sup_v_d = !wd_off && detect_on && cnt_q >= sup_cyc; // [RULE_16]
      gnd_v_d = !wd_off && detect_on && cnt_q >= gnd_cyc; // [RULE_17]
      // Short judged only after its wait, evaluation on
      sup_f_d = sup_v_d && !safety_off && sup_s2; // [RULE_14]
      gnd_f_d = gnd_v_d && !safety_off && gnd_s2; // [RULE_14]
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 9'h000;
         wd_act_q <= 1'b1;
         sup_v_q <= 1'b0;
         gnd_v_q <= 1'b0;
         sup_f_q <= 1'b0;
         gnd_f_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         wd_act_q <= wd_act_d;
         sup_v_q <= sup_v_d;
         gnd_v_q <= gnd_v_d;
         sup_f_q <= sup_f_d;
         gnd_f_q <= gnd_f_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from flip-flops
   // ----------------------------------------------------------------
   assign first_converter_enable = en1_q;
   assign second_converter_enable = en2_q;
   assign first_offset_source_select = src1_q;
   assign second_offset_source_select = src2_q;
   assign first_offset_full_scale = fs1_q;
   assign second_offset_full_scale = fs2_q;
   assign seq_amplitude_scale = ampl_q;
   assign seq_integrator_cap = cap_q;
   assign seq_reference_current = iref_q;
   assign threshold_mv = thr_q;
   assign emitter_watchdog_active = wd_act_q;
   assign supply_result_valid = sup_v_q;
   assign ground_result_valid = gnd_v_q;
   assign short_to_supply = sup_f_q;
   assign short_to_ground = gnd_f_q;
   assign config_code_illegal = illegal_q;

endmodule

//--- sim/meg_link_sva.sv
// Link checker: shadow map judges each read
`timescale 1ns/1ns
module meg_link_sva (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata
);
   logic [7:0] shadow_q [meg_pkg::NREG];
   logic [7:0] rd_exp;
   logic [7:0] mask_cur;
   logic hit;
   int idx;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // Decode the link address against the register map
   always_comb begin
      hit = 1'b0;
      idx = 0;
      for (int i = 0; i < meg_pkg::NREG; i++) begin
         if (addr == meg_pkg::REG_ADDR[i]) begin
            hit = 1'b1;
            idx = i;
         end
      end
   end
   assign rd_exp = hit ? shadow_q[idx] : 8'h00;
   assign mask_cur = hit ? meg_pkg::REG_MASK[idx] : 8'h00;

   // Masked on entry so absent bits stay zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         shadow_q <= meg_pkg::REG_RESET;
      end else if (wr && hit) begin
         shadow_q[idx] <= wdata & meg_pkg::REG_MASK[idx];
      end
   end

   a_read_matches_map: assert property (
      rd |=> rdata == $past(rd_exp)) else $error("read data off map");
   a_idle_rdata_zero: assert property (
      !rd |=> rdata == 8'h00) else $error("read data outside slot");
   a_unmapped_reads_zero: assert property (
      rd && !hit |=> rdata == 8'h00) else $error("unmapped read not 0");
   a_unlisted_bits_zero: assert property (
      rd && hit |=> (rdata & ~$past(mask_cur)) == 8'h00)
      else $error("absent bit read as one");
   a_first_enable_bit: assert property (
      rd && addr == 8'h1B |=> rdata[4] == $past(shadow_q[2][4]))
      else $error("first enable bit lost");
   a_second_enable_bit: assert property (
      rd && addr == 8'h21 |=> rdata[4] == $past(shadow_q[8][4]))
      else $error("second enable bit lost");
   a_first_source_bit: assert property (
      rd && addr == 8'h1B |=> rdata[5] == $past(shadow_q[2][5]))
      else $error("first source bit lost");
   a_second_source_bit: assert property (
      rd && addr == 8'h21 |=> rdata[5] == $past(shadow_q[8][5]))
      else $error("second source bit lost");
   a_guard_off_bit: assert property (
      rd && addr == 8'h28 |=> rdata[7] == $past(shadow_q[14][7]))
      else $error("watchdog off bit lost");

   c_mapped_write: cover property (wr && hit);
   c_unmapped_read: cover property (rd && !hit);
   c_guard_read: cover property (rd && addr == 8'h28);
endmodule

//--- sim/modulator_and_emitter_guard_config_tb_top.sv
// Bench: host and bank joined by the link
`timescale 1ns/1ns
module modulator_and_emitter_guard_config_tb_top;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [2:0] sw_addr = 3'h0;
   logic [7:0] sw_wdata = 8'h00;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic detect_on = 1'b0;
   logic sup_pin = 1'b0;
   logic gnd_pin = 1'b0;
   logic [7:0] sw_rdata, fs1, fs2, thr;
   logic en1, en2, src1, src2, wd_act, sup_v, gnd_v, sup_s, gnd_s, bad;
   logic [3:0] ampl;
   logic [4:0] cap [4];
   logic [7:0] iref [4];
   int sup_cy [4] = '{50, 100, 200, 25};
   int gnd_cy [4] = '{50, 100, 200, 300};
   int error_cnt = 0;
   int n_tests = 0;

   always #20 clk = ~clk;

   meg_link_if meg_link_if_inst ();
   meg_host meg_host_inst (.clk(clk), .rstn(rstn), .link(meg_link_if_inst),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
      .sw_rdata(sw_rdata));
   meg_device meg_device_inst (.clk(clk), .rstn(rstn),
      .link(meg_link_if_inst), .detect_on(detect_on),
      .short_supply_pin(sup_pin), .short_ground_pin(gnd_pin),
      .first_converter_enable(en1), .second_converter_enable(en2),
      .first_offset_source_select(src1), .second_offset_source_select(src2),
      .first_offset_full_scale(fs1), .second_offset_full_scale(fs2),
      .seq_amplitude_scale(ampl), .seq_integrator_cap(cap),
      .seq_reference_current(iref), .threshold_mv(thr),
      .emitter_watchdog_active(wd_act), .supply_result_valid(sup_v),
      .ground_result_valid(gnd_v), .short_to_supply(sup_s),
      .short_to_ground(gnd_s), .config_code_illegal(bad));
   meg_link_sva meg_link_sva_inst (.clk(clk), .rstn(rstn),
      .addr(meg_link_if_inst.addr), .wdata(meg_link_if_inst.wdata),
      .wr(meg_link_if_inst.wr), .rd(meg_link_if_inst.rd),
      .rdata(meg_link_if_inst.rdata));

   // ------------------------------------------
   // Compare, bus and closing tasks
   // ------------------------------------------
   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp);
      n_tests++;
      if (got != exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic sw_write(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic sw_read(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      #1 d = sw_rdata;
   endtask
   // Link transfer: go, poll done under a bound, clear
   task automatic link_go(input logic [7:0] a, input logic [7:0] go);
      logic [7:0] st;
      int n;
      sw_write(meg_pkg::HOST_TARGET, a);
      sw_write(meg_pkg::HOST_GO, go);
      n = 0;
      st = 8'h00;
      while (st[meg_pkg::ST_DONE_BIT] !== 1'b1 && n < 20) begin
         sw_read(meg_pkg::HOST_STATUS, st);
         n++;
      end
      chk_cnt(int'(n < 20), 1);
      sw_write(meg_pkg::HOST_STATUS, 8'h01 << meg_pkg::ST_DONE_BIT);
   endtask
   task automatic link_wr(input logic [7:0] a, input logic [7:0] d);
      sw_write(meg_pkg::HOST_WDATA, d);
      link_go(a, 8'h01 << meg_pkg::GO_WRITE_BIT);
   endtask
   task automatic link_rd(input logic [7:0] a, output logic [7:0] d);
      link_go(a, 8'h01 << meg_pkg::GO_READ_BIT);
      sw_read(meg_pkg::HOST_RDATA, d);
   endtask
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ------------------------------------------
   // Scenarios
   // ------------------------------------------
   task automatic t_reset_and_masks();
      logic [7:0] d;
      chk_val(fs1, 8'h10);
      chk_val({wd_act, src2, src1, en2, en1}, 8'h10);
      for (int i = 0; i < meg_pkg::NREG; i++) begin
         link_rd(meg_pkg::REG_ADDR[i], d);
         chk_val(d, meg_pkg::REG_RESET[i]);
         link_wr(meg_pkg::REG_ADDR[i], 8'hFF);
         link_rd(meg_pkg::REG_ADDR[i], d);
         chk_val(d, meg_pkg::REG_MASK[i]);
         link_wr(meg_pkg::REG_ADDR[i], 8'h00);
      end
      link_wr(8'h27, 8'hFF);
      link_rd(8'h27, d);
      chk_val(d, 8'h00);
   endtask
   // All full-scale codes, modulator two inverted
   task automatic t_main_cfg();
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         link_wr(8'h1B, {2'b00, c[1], c[0], 1'b0, c});
         link_wr(8'h21, {2'b00, ~c[1], ~c[0], 1'b0, ~c});
         chk_val(fs1, 8'h01 << c);
         chk_val(fs2, 8'h01 << (~c));
         chk_val({6'h00, src1, en1}, {6'h00, c[1:0]});
         chk_val({6'h00, src2, en2}, {6'h00, ~c[1:0]});
      end
   endtask
   // Legal sequencer codes at and just below the top, then forbidden ones
   task automatic t_seq_fields();
      logic [7:0] ia [4] = '{8'h1D, 8'h1F, 8'h23, 8'h25};
      logic [7:0] ba [6] = '{8'h1D, 8'h1E, 8'h19, 8'h1A, 8'h1B, 8'h1C};
      logic [7:0] bv [6] = '{8'h10, 8'h20, 8'h01, 8'h08, 8'h08, 8'h05};
      logic [7:0] d;
      for (int k = 0; k < 4; k++) begin
         link_wr(ia[k], {2'b00, ~1'(k), 5'h0F - 5'(k)});
         link_wr(ia[k] + 8'h01, 8'h1F - 8'(k));
         chk_val({3'h0, cap[k]}, 8'h0F - 8'(k));
         chk_val(iref[k], 8'h1F - 8'(k));
      end
      chk_val({4'h0, ampl}, 8'h05);
      link_wr(8'h1C, {4'h0, meg_pkg::SCALE_0P625});
      link_wr(8'h22, {4'h0, meg_pkg::SCALE_1P000});
      chk_val({7'h00, bad}, 8'h00);
      for (int j = 0; j < 6; j++) begin
         link_wr(ba[j], bv[j]);
         link_rd(ba[j], d);
         chk_val({bad, d[6:0]}, {1'b1, bv[j][6:0]});
         link_wr(ba[j], (j == 5) ? 8'h04 : 8'h00);
         chk_val({7'h00, bad}, 8'h00);
      end
   endtask
   // Each threshold and wait code; one counter serves both waits
   task automatic t_guard();
      logic [1:0] g;
      int ns;
      int ng;
      for (int i = 0; i < 4; i++) begin
         g = 2'(i + 1);
         link_wr(8'h28, {2'b00, 2'(i), 2'(i), g});
         chk_val(thr, 8'(50 * (i + 1)));
         @(posedge clk);
         detect_on <= 1'b1;
         sup_pin <= 1'(i);
         gnd_pin <= ~1'(i);
         ns = 0;
         ng = 0;
         for (int n = 1; n < 400; n++) begin
            @(posedge clk);
            #1;
            if (ns == 0 && sup_v === 1'b1) ns = n;
            if (ng == 0 && gnd_v === 1'b1) ng = n;
         end
         chk_cnt(ng - ns, gnd_cy[g] - sup_cy[i]);
         chk_cnt(int'(ns > sup_cy[i] && ns < sup_cy[i] + 4), 1);
         chk_val({6'h00, gnd_s, sup_s}, {6'h00, ~1'(i), 1'(i)});
         if (i == 3) begin
            link_wr(8'h28, 8'h40);
            chk_val({5'h00, sup_v, gnd_s, sup_s}, 8'h04);
            link_wr(8'h28, 8'h80);
            chk_val({6'h00, wd_act, sup_v}, 8'h00);
         end
         @(posedge clk);
         detect_on <= 1'b0;
         repeat (3) @(posedge clk);
         #1 chk_val({6'h00, gnd_v, sup_v}, 8'h00);
      end
   endtask

   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_reset_and_masks();
      t_main_cfg();
      t_seq_fields();
      t_guard();
      give_verdict();
   end

   // Watchdog, about 3000 cycles needed, 50000 allowed
   initial begin
      #2000000;
      error_cnt++;
      give_verdict();
   end
endmodule
